/* scsf_pkg.sv */
// Constants, field layout and carrier types for the serial channel status flags.
// Assumes one clock domain; all event inputs arrive from same-clock receiver,
// transmitter and phase-lock logic.
package scsf_pkg;

  localparam logic [2:0] ADDR_RX_STATUS = 3'h0;
  localparam logic [2:0] ADDR_TR_STATUS = 3'h1;
  localparam logic [2:0] ADDR_CONFIG = 3'h2;
  localparam logic [2:0] ADDR_CHAR_LEN = 3'h3;
  localparam logic [2:0] ADDR_COMMAND = 3'h4;

  localparam int RS_SHORT = 4;
  localparam int RS_BRK_END = 3;
  localparam int RS_BRK_START = 2;
  localparam int RS_ERR = 1;
  localparam int RS_PAR = 0;
  localparam int TR_EMPTY = 7;
  localparam int TR_CTS = 6;
  localparam int TR_FRAME = 5;
  localparam int TR_ACK = 4;
  localparam int TR_DPLL = 3;

  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_BISYNC = 2;
  localparam int CFG_X16 = 3;
  localparam int CFG_CTS_EN = 4;
  localparam int CFG_FCS_Q = 5;
  localparam int CFG_DPLL_TX = 6;
  localparam int CFG_FM = 7;

  localparam int CMD_RESET_RX = 0;
  localparam int CMD_RESET_TX = 1;
  localparam int CMD_GO_ON_POLL = 2;

  localparam logic [7:0] RESET_STATUS = 8'h00;
  localparam logic [7:0] RESET_CONFIG = 8'h00;
  localparam logic [1:0] RESET_CHAR_LEN = 2'h0;

  localparam logic [3:0] BRK_END_TICKS_1X = 4'h1;
  localparam logic [3:0] BRK_END_TICKS_16X = 4'h8;
  localparam logic [7:0] FLAG_PATTERN = 8'h7E;
  localparam logic [7:0] EOP_PATTERN = 8'h7F;
  localparam logic [15:0] IDLE_PATTERN = 16'h7FFF;
  localparam logic [7:0] TURN_PATTERN = 8'h00;
  localparam logic [1:0] DPLL_MISS_LIMIT = 2'h2;
  localparam logic [3:0] CHAR_LEN_BASE = 4'h5;

  typedef enum logic [1:0] {
    MODE_ASYNC = 2'h0,
    MODE_CHAR = 2'h1,
    MODE_BIT = 2'h3,
    MODE_LOOP = 2'h2
  } scsf_mode_t;

  // Character completion report from the receiver, one-cycle done strobe
  typedef struct packed {
    logic done;
    logic allZero;
    logic stopLow;
    logic parityBad;
    logic syncSearch;
    logic lastInfo;
    logic lastCheck;
    logic fcsBad;
    logic crcNonResidue;
    logic shortFrame;
    logic residual;
    logic [2:0] residualLen;
  } scsf_rx_char_t;

  // Transmitter events, each a one-cycle pulse except the levels noted
  typedef struct packed {
    logic charStart;
    logic padChar;
    logic shiftDone;
    logic queueEmpty;
    logic readyToStart;
    logic eomStart;
    logic unitStart;
    logic queueLoad;
  } scsf_tx_evt_t;

  // Status bits that travel with a character through the receive queue
  typedef struct packed {
    logic shortFrame;
    logic err;
    logic par;
  } scsf_qstat_t;

endpackage : scsf_pkg

/* scsf_status_flags.sv */
// Receiver and transmitter/receiver status flags for one serial channel.
// Assumes the receive queue itself lives outside and carries scsf_qstat_t
// beside each character; rxd and cts_n are raw pins.
//
// Overview of operation
// - Bit and loop modes: closing flag with missing fields sets short frame.
// - Async: break end after line marks one 1x clock or eight 16x clocks.
// - Bit mode: zero plus fifteen ones flags idle; only outside a frame.
// - Loop: eight zeros outside a frame flag turnaround.
// - Async: all-zero character including parity and stop flags break start.
// - Break queues one zero character, then blocks until end and new character.
// - Character mode: sync detect set one bit time after sync match.
// - Bit and loop modes: flag detect one bit time after 01111110 seen.
// - Async: framing error only on low first stop bit centre, never for breaks.
// - Bisync: bad block check sets error, queued with last or check byte.
// - Other character modes: error per character while checker not at residue.
// - Bit and loop modes: bad frame check sets error on last or check byte.
// - Parity error leaves queued data intact; ignored during sync search.
// - Residual length mismatch queued; actual length held unqueued.
// - Unused status bits read zero; upper bits OR into summary.
// - Write ones or reset clears; transmit reset top four, receive low four.
// - Transmitter empty after one real character; async holds line at mark.
// - Non-loop modes: gated clear-to-send negated at start sets underrun; async re-asserts.
// - Loop: pending poll command plus end-of-poll starts sending, sets flag.
// - Non-async modes: frame complete set when end-of-message sequence begins.
// - Send acknowledge set at each commanded break, sync, flag or abort.
// - FM mode: two missed transitions set phase-lock error unless it clocks tx.
// - Queued status bits OR into the register when their character reaches head.
`timescale 1ns/1ps
module scsf_status_flags (
  input wire logic refClk,
  input wire logic rst_n,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic rxdPin,
  input wire logic ctsPin_n,
  input wire logic rxClkTick,
  input wire logic rxBitTick,
  input wire logic rxBit,
  input wire logic rxInFrame,
  input wire logic rxSyncMatch,
  input wire scsf_pkg::scsf_rx_char_t rxChar,
  output logic rxQueuePush,
  output scsf_pkg::scsf_qstat_t rxQueueStatus,
  input wire logic rxHeadPop,
  input wire scsf_pkg::scsf_qstat_t rxHeadStatus,
  input wire scsf_pkg::scsf_tx_evt_t txEvt,
  output logic txHoldMark,
  output logic txGoActive,
  input wire logic dpllBitTick,
  input wire logic dpllTransSeen,
  output logic dpllForceSearch,
  output logic channelSummary
);

  logic [7:0] rxStatus;
  logic [7:0] trStatus;
  logic [7:0] cfgReg;
  logic [1:0] charLen;
  logic [2:0] residualField;
  logic rxdMeta, rxdSync, ctsMeta, ctsSync_n;
  logic [15:0] bitShift, bitNext;
  logic flagPending, syncPending;
  logic breakActive, breakEnded, breakBlock;
  logic [3:0] markCount;
  logic sentOne, goPollPending;
  logic [1:0] missCount;

  scsf_pkg::scsf_mode_t mode;
  logic isAsync, isChar, isBitLoop, isLoop, bisync;
  logic wrRx, wrTr, cmdResetRx, cmdResetTx;
  logic breakStart, breakEnd, idleSeen, turnSeen, eopSeen, flagSet, syncSet;
  logic frameErr, parErr, crcErr, resErr;
  logic tagByte;
  logic ctsSet, dpllErr;
  logic [3:0] markNeed;
  logic [7:0] rxSet, trSet, rxClr, trClr;

  assign mode = scsf_pkg::scsf_mode_t'(cfgReg[scsf_pkg::CFG_MODE_LSB +: 2]);
  assign isAsync = (mode == scsf_pkg::MODE_ASYNC);
  assign isChar = (mode == scsf_pkg::MODE_CHAR);
  assign isLoop = (mode == scsf_pkg::MODE_LOOP);
  assign isBitLoop = (mode == scsf_pkg::MODE_BIT) || isLoop;
  assign bisync = cfgReg[scsf_pkg::CFG_BISYNC];

  assign wrRx = regWrite && (regAddr == scsf_pkg::ADDR_RX_STATUS);
  assign wrTr = regWrite && (regAddr == scsf_pkg::ADDR_TR_STATUS);
  assign cmdResetRx = regWrite && (regAddr == scsf_pkg::ADDR_COMMAND) && regWrData[scsf_pkg::CMD_RESET_RX];
  assign cmdResetTx = regWrite && (regAddr == scsf_pkg::ADDR_COMMAND) && regWrData[scsf_pkg::CMD_RESET_TX];

  // Pins cross into the clock domain before anything looks at them
  always_ff @(posedge refClk or negedge rst_n) begin
    if (!rst_n) begin
      rxdMeta <= 1'b1;
      rxdSync <= 1'b1;
      ctsMeta <= 1'b1;
      ctsSync_n <= 1'b1;
    end else begin
      rxdMeta <= rxdPin;
      rxdSync <= rxdMeta;
      ctsMeta <= ctsPin_n;
      ctsSync_n <= ctsMeta;
    end
  end

  // Configuration registers
  always_ff @(posedge refClk or negedge rst_n) begin
    if (!rst_n) begin
      cfgReg <= scsf_pkg::RESET_CONFIG;
      charLen <= scsf_pkg::RESET_CHAR_LEN;
    end else if (regWrite && regAddr == scsf_pkg::ADDR_CONFIG) begin
      cfgReg <= regWrData;
    end else if (regWrite && regAddr == scsf_pkg::ADDR_CHAR_LEN) begin
      charLen <= regWrData[1:0];
    end
  end

  // Serial bit pattern shift register, newest bit at the bottom
  always_ff @(posedge refClk or negedge rst_n) begin
    if (!rst_n) begin
      bitShift <= 16'h0000;
    end else if (rxBitTick) begin
      bitShift <= {bitShift[14:0], rxBit};
    end
  end

  // Patterns include the bit arriving now, so a match is seen on its last bit
  assign bitNext = {bitShift[14:0], rxBit};
  assign idleSeen = rxBitTick && (mode == scsf_pkg::MODE_BIT) && !rxInFrame
    && (bitNext == scsf_pkg::IDLE_PATTERN);
  assign turnSeen = rxBitTick && isLoop && !rxInFrame
    && (bitNext[7:0] == scsf_pkg::TURN_PATTERN);
  assign eopSeen = rxBitTick && isLoop && (bitNext[7:0] == scsf_pkg::EOP_PATTERN);

  // Flag and sync detections are reported one bit time after the match
  always_ff @(posedge refClk or negedge rst_n) begin
    if (!rst_n) begin
      flagPending <= 1'b0;
      syncPending <= 1'b0;
    end else if (rxBitTick) begin
      flagPending <= isBitLoop && (bitNext[7:0] == scsf_pkg::FLAG_PATTERN);
      syncPending <= isChar && rxSyncMatch;
    end
  end

  assign flagSet = rxBitTick && flagPending;
  assign syncSet = rxBitTick && syncPending;

  // Break tracking
  // A zero character after break end is a fresh break
  assign breakStart = isAsync && rxChar.done && rxChar.allZero && (!breakActive || breakEnded);
  assign markNeed = cfgReg[scsf_pkg::CFG_X16] ? scsf_pkg::BRK_END_TICKS_16X : scsf_pkg::BRK_END_TICKS_1X;
  assign breakEnd = breakActive && !breakEnded && rxClkTick && rxdSync
    && (markCount + 4'h1 >= markNeed);

  always_ff @(posedge refClk or negedge rst_n) begin
    if (!rst_n) begin
      markCount <= 4'h0;
    end else if (!breakActive || !rxdSync || breakEnded) begin
      markCount <= 4'h0;
    end else if (rxClkTick) begin
      markCount <= markCount + 4'h1;
    end
  end

  always_ff @(posedge refClk or negedge rst_n) begin
    if (!rst_n) begin
      breakActive <= 1'b0;
      breakEnded <= 1'b0;
      breakBlock <= 1'b0;
    end else if (cmdResetRx || !isAsync) begin
      breakActive <= 1'b0;
      breakEnded <= 1'b0;
      breakBlock <= 1'b0;
    end else if (breakStart) begin
      breakActive <= 1'b1;
      breakEnded <= 1'b0;
      breakBlock <= 1'b1;
    end else if (breakEnd) begin
      breakEnded <= 1'b1;
    end else if (breakEnded && rxChar.done) begin
      breakActive <= 1'b0;
      breakEnded <= 1'b0;
      breakBlock <= 1'b0;
    end
  end

  // Per-character error bits that travel with the character
  assign frameErr = isAsync && rxChar.stopLow && !rxChar.allZero;
  assign tagByte = cfgReg[scsf_pkg::CFG_FCS_Q] ? rxChar.lastCheck : rxChar.lastInfo;
  always_comb begin
    crcErr = 1'b0;
    if (isChar && bisync) begin
      crcErr = tagByte && rxChar.fcsBad;
    end else if (isChar) begin
      crcErr = rxChar.crcNonResidue;
    end else if (isBitLoop) begin
      crcErr = tagByte && rxChar.fcsBad;
    end
  end
  // Only the flag is raised; the stored parity bit is the receiver's own
  assign parErr = (isAsync || (isChar && !rxChar.syncSearch)) && rxChar.parityBad;
  assign resErr = isBitLoop && tagByte && rxChar.residual
    && ({1'b0, rxChar.residualLen} != scsf_pkg::CHAR_LEN_BASE + {2'b00, charLen});

  assign rxQueuePush = rxChar.done && (!breakBlock || breakStart || (breakEnded && !breakStart));
  assign rxQueueStatus.shortFrame = isBitLoop && rxChar.shortFrame;
  assign rxQueueStatus.err = frameErr || crcErr;
  assign rxQueueStatus.par = isBitLoop ? resErr : parErr;

  // Receiver status register
  always_comb begin
    rxSet = 8'h00;
    rxSet[scsf_pkg::RS_BRK_END] = (isAsync && breakEnd) || idleSeen || turnSeen;
    rxSet[scsf_pkg::RS_BRK_START] = breakStart || flagSet || syncSet;
    if (rxHeadPop) begin
      rxSet[scsf_pkg::RS_SHORT] = rxHeadStatus.shortFrame;
      rxSet[scsf_pkg::RS_ERR] = rxHeadStatus.err;
      rxSet[scsf_pkg::RS_PAR] = rxHeadStatus.par;
    end
    rxClr = (wrRx ? regWrData : 8'h00) | (cmdResetRx ? 8'hFF : 8'h00);
  end

  always_ff @(posedge refClk or negedge rst_n) begin
    if (!rst_n) begin
      rxStatus <= scsf_pkg::RESET_STATUS;
    end else begin
      rxStatus <= ((rxStatus & ~rxClr) | rxSet) & 8'h1F;
    end
  end

  // Residual length of the most recent residual character, not queued
  always_ff @(posedge refClk or negedge rst_n) begin
    if (!rst_n) begin
      residualField <= 3'h0;
    end else if (cmdResetRx) begin
      residualField <= 3'h0;
    end else if (isBitLoop && rxChar.done && rxChar.residual) begin
      residualField <= rxChar.residualLen;
    end
  end

  // Transmitter side
  always_ff @(posedge refClk or negedge rst_n) begin
    if (!rst_n) begin
      sentOne <= 1'b0;
    end else if (cmdResetTx) begin
      sentOne <= 1'b0;
    end else if (txEvt.charStart && !txEvt.padChar) begin
      sentOne <= 1'b1;
    end
  end

  always_ff @(posedge refClk or negedge rst_n) begin
    if (!rst_n) begin
      txHoldMark <= 1'b0;
    end else if (cmdResetTx || !isAsync || txEvt.queueLoad) begin
      txHoldMark <= 1'b0;
    end else if (txEvt.shiftDone && txEvt.queueEmpty && sentOne) begin
      txHoldMark <= 1'b1;
    end
  end

  always_ff @(posedge refClk or negedge rst_n) begin
    if (!rst_n) begin
      goPollPending <= 1'b0;
    end else if (cmdResetTx || !isLoop || eopSeen) begin
      goPollPending <= 1'b0;
    end else if (regWrite && regAddr == scsf_pkg::ADDR_COMMAND && regWrData[scsf_pkg::CMD_GO_ON_POLL]) begin
      goPollPending <= 1'b1;
    end
  end

  // One-cycle pulse telling the transmitter to turn the end-of-poll into a flag
  always_ff @(posedge refClk or negedge rst_n) begin
    if (!rst_n) begin
      txGoActive <= 1'b0;
    end else begin
      txGoActive <= goPollPending && eopSeen;
    end
  end

  // Async keeps re-raising underrun while the input stays negated
  assign ctsSet = isLoop ? (goPollPending && eopSeen)
    : cfgReg[scsf_pkg::CFG_CTS_EN] && ctsSync_n
      && (txEvt.readyToStart || (isAsync && wrTr && regWrData[scsf_pkg::TR_CTS]));

  // Phase-lock watch: two bit periods in a row without a transition
  always_ff @(posedge refClk or negedge rst_n) begin
    if (!rst_n) begin
      missCount <= 2'h0;
    end else if (!cfgReg[scsf_pkg::CFG_FM] || cfgReg[scsf_pkg::CFG_DPLL_TX] || dpllErr) begin
      missCount <= 2'h0;
    end else if (dpllBitTick) begin
      missCount <= dpllTransSeen ? 2'h0 : missCount + 2'h1;
    end
  end

  assign dpllErr = cfgReg[scsf_pkg::CFG_FM] && !cfgReg[scsf_pkg::CFG_DPLL_TX] && dpllBitTick
    && !dpllTransSeen && (missCount + 2'h1 == scsf_pkg::DPLL_MISS_LIMIT);

  always_ff @(posedge refClk or negedge rst_n) begin
    if (!rst_n) begin
      dpllForceSearch <= 1'b0;
    end else begin
      dpllForceSearch <= dpllErr;
    end
  end

  always_comb begin
    trSet = 8'h00;
    trSet[scsf_pkg::TR_EMPTY] = txEvt.shiftDone && txEvt.queueEmpty && sentOne;
    trSet[scsf_pkg::TR_CTS] = ctsSet;
    trSet[scsf_pkg::TR_FRAME] = !isAsync && txEvt.eomStart;
    trSet[scsf_pkg::TR_ACK] = txEvt.unitStart;
    trSet[scsf_pkg::TR_DPLL] = dpllErr;
    trClr = (wrTr ? (regWrData & 8'hF8) : 8'h00)
      | (cmdResetTx ? 8'hF0 : 8'h00) | (cmdResetRx ? 8'h0F : 8'h00);
  end

  // Set wins over any clear in the same cycle
  always_ff @(posedge refClk or negedge rst_n) begin
    if (!rst_n) begin
      trStatus <= scsf_pkg::RESET_STATUS;
    end else begin
      trStatus <= ((trStatus & ~trClr) | trSet) & 8'hF8;
    end
  end

  always_ff @(posedge refClk or negedge rst_n) begin
    if (!rst_n) begin
      channelSummary <= 1'b0;
    end else begin
      channelSummary <= (|trStatus[7:3]) || (|rxStatus);
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge refClk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        scsf_pkg::ADDR_RX_STATUS: regRdData <= rxStatus;
        scsf_pkg::ADDR_TR_STATUS: regRdData <= {trStatus[7:3], isBitLoop ? residualField : 3'h0};
        scsf_pkg::ADDR_CONFIG: regRdData <= cfgReg;
        scsf_pkg::ADDR_CHAR_LEN: regRdData <= {6'h00, charLen};
        default: regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule : scsf_status_flags

/* scsf_status_flags_assertions.sv */
// Port checker for the serial channel status flags.
// Assumes one clock domain; bound to every scsf_status_flags instance.
`timescale 1ns/1ps
module scsf_status_flags_assertions (
  input wire logic refClk,
  input wire logic rst_n,
  input wire logic [2:0] regAddr,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire scsf_pkg::scsf_rx_char_t rxChar,
  input wire logic rxQueuePush,
  input wire scsf_pkg::scsf_qstat_t rxQueueStatus,
  input wire scsf_pkg::scsf_tx_evt_t txEvt,
  input wire logic txHoldMark,
  input wire logic txGoActive,
  input wire logic dpllBitTick,
  input wire logic dpllTransSeen,
  input wire logic dpllForceSearch,
  input wire logic channelSummary
);
  default clocking cb @(posedge refClk); endclocking
  default disable iff (!rst_n);

  property p_rd_idle;
    !$past(regRead) |-> regRdData == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read");
  property p_rx_unused;
    $past(regRead) && $past(regAddr) == scsf_pkg::ADDR_RX_STATUS |-> regRdData[7:5] == 3'h0;
  endproperty
  a_rx_unused: assert property (p_rx_unused) else $error("unused receiver bits not zero");
  property p_cmd_zero;
    $past(regRead) && $past(regAddr) == scsf_pkg::ADDR_COMMAND |-> regRdData == 8'h00;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("command register read not zero");
  // Summary and read data both reflect the status of the previous cycle
  property p_summary;
    $past(regRead) && $past(regAddr) <= scsf_pkg::ADDR_TR_STATUS && regRdData[7:3] != 5'h00
      |-> channelSummary;
  endproperty
  a_summary: assert property (p_summary) else $error("summary low with status set");
  property p_push_done;
    rxQueuePush |-> rxChar.done;
  endproperty
  a_push_done: assert property (p_push_done) else $error("queue push without character");
  property p_par_clean;
    rxQueuePush && !rxChar.parityBad && !rxChar.residual |-> !rxQueueStatus.par;
  endproperty
  a_par_clean: assert property (p_par_clean) else $error("parity flag without cause");
  property p_brk_noerr;
    rxQueuePush && rxChar.allZero && !rxChar.fcsBad && !rxChar.crcNonResidue |-> !rxQueueStatus.err;
  endproperty
  a_brk_noerr: assert property (p_brk_noerr) else $error("framing error on break");
  property p_force;
    dpllForceSearch |-> $past(dpllBitTick) && !$past(dpllTransSeen);
  endproperty
  a_force: assert property (p_force) else $error("search forced without miss");
  property p_go_pulse;
    txGoActive |=> !txGoActive;
  endproperty
  a_go_pulse: assert property (p_go_pulse) else $error("go active longer than a cycle");
  property p_hold;
    $rose(txHoldMark) |-> $past(txEvt.shiftDone) && $past(txEvt.queueEmpty);
  endproperty
  a_hold: assert property (p_hold) else $error("mark hold without empty");
endmodule : scsf_status_flags_assertions

bind scsf_status_flags scsf_status_flags_assertions u_chk (.*);

/* scsf_remote_station.sv */
// Far-end station model: receive line, clear-to-send and receiver ticks.
// Assumes the bench calls its tasks right after a rising edge.
`timescale 1ns/1ps
module scsf_remote_station (
  input wire logic refClk,
  output logic rxdPin,
  output logic ctsPin_n,
  output logic rxClkTick,
  output logic rxBitTick,
  output logic rxBit
);
  initial begin
    {rxClkTick, rxBitTick, ctsPin_n} = '0;
    {rxdPin, rxBit} = 2'h3;
  end
  // Between ticks the bit line shows the inverse so stale data never passes
  task automatic sendBits(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge refClk);
      rxBit <= v[i];
      rxBitTick <= 1'b1;
      @(posedge refClk);
      rxBitTick <= 1'b0;
      rxBit <= ~v[i];
    end
  endtask : sendBits
  // Line level settles through the two-stage sync before ticks are counted
  task automatic lineTicks(input logic lvl, input int n);
    rxdPin <= lvl;
    repeat (3) @(posedge refClk);
    for (int i = 0; i < n; i++) begin
      rxClkTick <= 1'b1;
      @(posedge refClk);
      rxClkTick <= 1'b0;
      @(posedge refClk);
    end
  endtask : lineTicks
  task automatic setCts(input logic negated);
    ctsPin_n <= negated;
    repeat (3) @(posedge refClk);
  endtask : setCts
endmodule : scsf_remote_station

/* tb_top.sv */
// Self-checking bench for the serial channel status flags.
// Assumes the station model and the port checker are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic refClk, rst_n, regWrite, regRead, rxInFrame, rxSyncMatch, rxHeadPop;
  logic dpllBitTick, dpllTransSeen, goSeen, forceSeen;
  logic rxdPin, ctsPin_n, rxClkTick, rxBitTick, rxBit;
  logic rxQueuePush, txHoldMark, txGoActive, dpllForceSearch, channelSummary;
  logic [2:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic [31:0] seed = 32'h565EF4CA;
  int nFail, nTests, cycles;
  scsf_pkg::scsf_rx_char_t rxChar, c;
  scsf_pkg::scsf_qstat_t rxQueueStatus, rxHeadStatus;
  scsf_pkg::scsf_tx_evt_t txEvt;

  scsf_status_flags u_dut (.*);
  scsf_remote_station u_far (.*);

  initial begin
    refClk = 1'b0;
    forever #2.5 refClk = ~refClk;
  end
  always @(posedge refClk) begin
    cycles++;
    goSeen <= goSeen | txGoActive;
    forceSeen <= forceSeen | dpllForceSearch;
    if (cycles == 20000) begin
      nFail++;
      wrapUp();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [7:0] b(input int i);
    return 8'h01 << i;
  endfunction : b
  // Async character: always pushed, framing only off a break, parity as seen
  function automatic logic [3:0] expAsync(input scsf_pkg::scsf_rx_char_t x);
    return {1'b1, 1'b0, x.stopLow & ~x.allZero, x.parityBad};
  endfunction : expAsync
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge refClk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge refClk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rdChk(input logic [2:0] a, input logic [7:0] e);
    @(posedge refClk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge refClk);
    regRead <= 1'b0;
    @(negedge refClk);
    check(regRdData, e);
  endtask : rdChk
  // Push and queued status are combinational, so look while done is high
  task automatic charDone(input scsf_pkg::scsf_rx_char_t x, input logic [3:0] e);
    @(posedge refClk);
    rxChar <= x;
    @(negedge refClk);
    check({4'h0, rxQueuePush, rxQueueStatus & {3{rxQueuePush}}}, {4'h0, e});
    @(posedge refClk);
    rxChar <= '0;
  endtask : charDone
  task automatic popHead(input logic [2:0] s);
    @(posedge refClk);
    rxHeadStatus <= s;
    rxHeadPop <= 1'b1;
    @(posedge refClk);
    rxHeadPop <= 1'b0;
  endtask : popHead
  // Bits: start, pad, shift done, queue empty, ready, end of message, unit, load
  task automatic txPulse(input logic [7:0] e);
    @(posedge refClk);
    txEvt <= e;
    @(posedge refClk);
    txEvt <= '0;
    @(negedge refClk);
  endtask : txPulse
  task automatic dpllBit(input logic seen);
    @(posedge refClk);
    dpllBitTick <= 1'b1;
    dpllTransSeen <= seen;
    @(posedge refClk);
    dpllBitTick <= 1'b0;
  endtask : dpllBit
  task automatic wrapUp;
    $display("Counts: %0d checks, %0d mismatches", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrapUp

  initial begin
    {rst_n, regAddr, regWrData, regWrite, regRead, rxInFrame, rxSyncMatch, rxHeadPop} = '0;
    {dpllBitTick, dpllTransSeen, goSeen, forceSeen, rxChar, rxHeadStatus, txEvt} = '0;
    repeat (10) @(posedge refClk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rdChk(3'(a), scsf_pkg::RESET_STATUS);
    end
    wr(3'h7, 8'hFF);
    rdChk(3'h7, 8'h00);
    $display("Done: reset values");
    c = '0;
    {c.done, c.allZero, c.stopLow} = 3'h7;
    u_far.lineTicks(1'b0, 1);
    charDone(c, 4'h8);
    rdChk(scsf_pkg::ADDR_RX_STATUS, b(scsf_pkg::RS_BRK_START));
    charDone(c, 4'h0);
    u_far.lineTicks(1'b1, 1);
    rdChk(scsf_pkg::ADDR_RX_STATUS, b(scsf_pkg::RS_BRK_START) | b(scsf_pkg::RS_BRK_END));
    wr(scsf_pkg::ADDR_RX_STATUS, 8'hFF);
    wr(scsf_pkg::ADDR_CONFIG, b(scsf_pkg::CFG_X16));
    u_far.lineTicks(1'b0, 1);
    charDone(c, 4'h8);
    u_far.lineTicks(1'b1, 7);
    rdChk(scsf_pkg::ADDR_RX_STATUS, b(scsf_pkg::RS_BRK_START));
    u_far.lineTicks(1'b1, 1);
    rdChk(scsf_pkg::ADDR_RX_STATUS, b(scsf_pkg::RS_BRK_START) | b(scsf_pkg::RS_BRK_END));
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      c = '0;
      {c.done, c.stopLow, c.parityBad} = {1'b1, seed[1:0]};
      charDone(c, expAsync(c));
    end
    wr(scsf_pkg::ADDR_RX_STATUS, 8'hFF);
    popHead(3'h6);
    rdChk(scsf_pkg::ADDR_RX_STATUS, b(scsf_pkg::RS_SHORT) | b(scsf_pkg::RS_ERR));
    popHead(3'h1);
    rdChk(scsf_pkg::ADDR_RX_STATUS, 8'h13);
    $display("Done: async receive");
    wr(scsf_pkg::ADDR_CONFIG, {6'h00, scsf_pkg::MODE_BIT});
    wr(scsf_pkg::ADDR_COMMAND, b(scsf_pkg::CMD_RESET_RX));
    u_far.sendBits(16'h007E, 8);
    u_far.sendBits(16'h0000, 1);
    rdChk(scsf_pkg::ADDR_RX_STATUS, b(scsf_pkg::RS_BRK_START));
    wr(scsf_pkg::ADDR_RX_STATUS, 8'hFF);
    rxInFrame <= 1'b1;
    u_far.sendBits(16'h7FFF, 16);
    rdChk(scsf_pkg::ADDR_RX_STATUS, 8'h00);
    rxInFrame <= 1'b0;
    u_far.sendBits(16'h7FFF, 16);
    rdChk(scsf_pkg::ADDR_RX_STATUS, b(scsf_pkg::RS_BRK_END));
    c = '0;
    {c.done, c.shortFrame, c.lastInfo, c.fcsBad, c.residual, c.residualLen} = 8'hFB;
    charDone(c, 4'hF);
    rdChk(scsf_pkg::ADDR_TR_STATUS, 8'h03);
    wr(scsf_pkg::ADDR_CONFIG, {6'h00, scsf_pkg::MODE_LOOP});
    wr(scsf_pkg::ADDR_COMMAND, b(scsf_pkg::CMD_RESET_RX));
    u_far.sendBits(16'h0000, 8);
    rdChk(scsf_pkg::ADDR_RX_STATUS, b(scsf_pkg::RS_BRK_END));
    wr(scsf_pkg::ADDR_COMMAND, b(scsf_pkg::CMD_GO_ON_POLL));
    u_far.sendBits(16'h007F, 8);
    rdChk(scsf_pkg::ADDR_TR_STATUS, b(scsf_pkg::TR_CTS));
    check({7'h00, goSeen}, 8'h01);
    $display("Done: bit and loop receive");
    wr(scsf_pkg::ADDR_CONFIG, {6'h00, scsf_pkg::MODE_CHAR});
    wr(scsf_pkg::ADDR_COMMAND, b(scsf_pkg::CMD_RESET_TX));
    txPulse(8'h30);
    txPulse(8'hC0);
    txPulse(8'h30);
    rdChk(scsf_pkg::ADDR_TR_STATUS, 8'h00);
    txPulse(8'h80);
    txPulse(8'h30);
    rdChk(scsf_pkg::ADDR_TR_STATUS, b(scsf_pkg::TR_EMPTY));
    txPulse(8'h04);
    wr(scsf_pkg::ADDR_TR_STATUS, b(scsf_pkg::TR_ACK));
    txPulse(8'h02);
    rdChk(scsf_pkg::ADDR_TR_STATUS, 8'hB0);
    wr(scsf_pkg::ADDR_COMMAND, b(scsf_pkg::CMD_RESET_TX));
    rdChk(scsf_pkg::ADDR_TR_STATUS, 8'h00);
    wr(scsf_pkg::ADDR_CONFIG, 8'h00);
    txPulse(8'h80);
    txPulse(8'h30);
    check({7'h00, txHoldMark}, 8'h01);
    txPulse(8'h01);
    check({7'h00, txHoldMark}, 8'h00);
    wr(scsf_pkg::ADDR_CONFIG, b(scsf_pkg::CFG_CTS_EN));
    wr(scsf_pkg::ADDR_COMMAND, b(scsf_pkg::CMD_RESET_TX));
    u_far.setCts(1'b1);
    txPulse(8'h08);
    rdChk(scsf_pkg::ADDR_TR_STATUS, b(scsf_pkg::TR_CTS));
    wr(scsf_pkg::ADDR_TR_STATUS, b(scsf_pkg::TR_CTS));
    rdChk(scsf_pkg::ADDR_TR_STATUS, b(scsf_pkg::TR_CTS));
    u_far.setCts(1'b0);
    wr(scsf_pkg::ADDR_TR_STATUS, b(scsf_pkg::TR_CTS));
    rdChk(scsf_pkg::ADDR_TR_STATUS, 8'h00);
    $display("Done: transmitter");
    wr(scsf_pkg::ADDR_CONFIG, b(scsf_pkg::CFG_FM));
    dpllBit(1'b0);
    dpllBit(1'b1);
    dpllBit(1'b0);
    rdChk(scsf_pkg::ADDR_TR_STATUS, 8'h00);
    dpllBit(1'b0);
    rdChk(scsf_pkg::ADDR_TR_STATUS, b(scsf_pkg::TR_DPLL));
    check({7'h00, forceSeen}, 8'h01);
    wr(scsf_pkg::ADDR_COMMAND, b(scsf_pkg::CMD_RESET_RX));
    rdChk(scsf_pkg::ADDR_TR_STATUS, 8'h00);
    wr(scsf_pkg::ADDR_CONFIG, b(scsf_pkg::CFG_FM) | b(scsf_pkg::CFG_DPLL_TX));
    dpllBit(1'b0);
    dpllBit(1'b0);
    rdChk(scsf_pkg::ADDR_TR_STATUS, 8'h00);
    wr(scsf_pkg::ADDR_CONFIG, {6'h00, scsf_pkg::MODE_CHAR});
    rxSyncMatch <= 1'b1;
    u_far.sendBits(16'h0000, 1);
    rxSyncMatch <= 1'b0;
    rdChk(scsf_pkg::ADDR_RX_STATUS, 8'h00);
    u_far.sendBits(16'h0000, 1);
    rdChk(scsf_pkg::ADDR_RX_STATUS, b(scsf_pkg::RS_BRK_START));
    c = '0;
    {c.done, c.parityBad, c.syncSearch} = 3'h7;
    charDone(c, 4'h8);
    c = '0;
    {c.done, c.crcNonResidue} = 2'h3;
    charDone(c, 4'hA);
    $display("Done: dpll and character mode");
    wrapUp();
  end
endmodule : tb_top
